// *** src/obc_pkg.sv ***
/*
 * Constants for the option byte configuration decoder: byte layouts,
 * field positions, erased values, field encodings and phase lengths.
 * Assumes one 10 MHz clock and a synchronous active-high reset.
 */
// Notes on behaviour
// - Byte0 bit7 selects reset on halt entry
// - Byte0 bit6 selects hardware or software watchdog
// - Byte0 bit4 low turns voltage detector on
// - Byte0 bit3 low enables clock doubler
// - Byte0 bits2:1 select 64, 44, 32 pins
// - Unbonded pads forced input with pull-up
// - Byte0 bit0 low enables read-out protection
// - Protected option erase wipes user memory first
// - Byte1 bit7 remaps timer and serial pins
// - Byte1 bit6 routes second capture input
// - Byte1 bits5:4 select main clock source
// - Byte1 bits3:2 select oscillator range
// - Byte1 bit0 picks 4096 or 256 cycles
// - Option bytes reachable only in programming mode
// - Erased storage reads as all ones
// - Blank parts select internal clock source
// - Mask parts hard-wire option values
package obc_pkg;

    // ==========================================================
    // Byte layout
    localparam int OPT_W = 8;
    localparam logic [7:0] OPT_ERASED = 8'hff;
    localparam logic [7:0] OPT0_DEFAULT = 8'hff;
    localparam logic [7:0] OPT1_DEFAULT = 8'hef;

    localparam int B0_HALT_RST = 7;
    localparam int B0_WDG_SW   = 6;
    localparam int B0_RSVD     = 5;
    localparam int B0_LVD_OFF  = 4;
    localparam int B0_DBL_OFF  = 3;
    localparam int B0_PKG_HI   = 2;
    localparam int B0_PKG_LO   = 1;
    localparam int B0_RDP_N    = 0;

    localparam int B1_REMAP1   = 7;
    localparam int B1_REMAP0   = 6;
    localparam int B1_CLK_HI   = 5;
    localparam int B1_CLK_LO   = 4;
    localparam int B1_RNG_HI   = 3;
    localparam int B1_RNG_LO   = 2;
    localparam int B1_RESET_PHASE_LENGTH_SEL     = 0;

    // ==========================================================
    // Encodings
    typedef enum logic [1:0] {
        OBC_PKG_32 = 2'h0,
        OBC_PKG_44 = 2'h1,
        OBC_PKG_64 = 2'h2
    } obc_pkg_sel_type;

    localparam logic [1:0] CLK_RESONATOR = 2'h0;
    localparam logic [1:0] CLK_RSVD      = 2'h1;
    localparam logic [1:0] CLK_INTERNAL  = 2'h2;
    localparam logic [1:0] CLK_EXTERNAL  = 2'h3;

    localparam logic [1:0] RANGE_LOW_POWER    = 2'h0;
    localparam logic [1:0] RANGE_MEDIUM_POWER = 2'h1;
    localparam logic [1:0] RANGE_MEDIUM_SPEED = 2'h2;
    localparam logic [1:0] RANGE_HIGH_SPEED   = 2'h3;

    // ==========================================================
    // Reset phase lengths in CPU cycles
    localparam int PHASE_W = 13;
    localparam logic [12:0] PHASE_LONG  = 13'h1000;
    localparam logic [12:0] PHASE_SHORT = 13'h0100;

    // Programming port commands
    typedef enum logic [1:0] {
        OBC_CMD_READ  = 2'h0,
        OBC_CMD_WRITE = 2'h1,
        OBC_CMD_ERASE = 2'h2
    } obc_cmd_type;

    // Memory wipe address width in bits; the wipe walks one word per clock
    localparam int WIPE_ADDR_W = 16;

endpackage

// *** src/obc_opt_cell.sv ***
/*
 * One option byte cell: programmable storage, or a constant in
 * mask parts. Erase returns all ones; programming only clears bits.
 * Assumes the caller gates writes by programming mode.
 */
module obc_opt_cell #(
    parameter bit         MASK_ROM  = 1'b0,
    parameter logic [7:0] ROM_VALUE = 8'hff,
    parameter logic [7:0] BLANK     = 8'hff
) (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       wr_i,
    input  wire logic       erase_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] value_o
);

    logic [7:0] store_r;
    logic [7:0] store_nxt;
    // Fresh storage starts blank at power-up, unlike after a device reset
    logic       blank_r = 1'b1;

    // ==========================================================
    // Storage survives the device reset; only the first reset seeds it
    assign store_nxt = erase_i ? obc_pkg::OPT_ERASED
                     : wr_i    ? (store_r & wdata_i)
                     : store_r;

    always_ff @(posedge clk_i)
    begin
        if (srst_i && blank_r)
        begin
            store_r <= BLANK;
            blank_r <= 1'b0;
        end
        else
        begin
            store_r <= store_nxt;
        end
    end

    assign value_o = MASK_ROM ? ROM_VALUE : store_r;

endmodule

// *** src/obc_decoder.sv ***
/*
 * Option byte configuration decoder. Holds two option bytes, reachable
 * only by the programming port while prog_mode_i is high, and latches
 * their decoded meaning at reset for clock, reset, watchdog and pin mux.
 * Assumes inputs synchronous to clk_i and a synchronous high reset.
 */
module obc_decoder #(
    parameter bit         MASK_ROM   = 1'b0,
    parameter logic [7:0] ROM_OPT0   = 8'hff,
    parameter logic [7:0] ROM_OPT1   = 8'hef,
    parameter int         WIPE_WORDS = 16'hf000
) (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        prog_mode_i,
    input  wire logic        prog_sel_i,
    input  wire logic [1:0]  prog_cmd_i,
    input  wire logic        prog_strobe_i,
    input  wire logic [7:0]  prog_wdata_i,
    output logic      [7:0]  prog_rdata_o,
    output logic             prog_busy_o,
    output logic             wipe_active_o,
    output logic [15:0]      wipe_addr_o,
    output logic             halt_entry_watchdog_reset_sel_o,
    output logic             watchdog_type_sel_o,
    output logic             low_voltage_detector_off_o,
    output logic             clock_doubler_en_o,
    output logic [1:0]       package_sel_o,
    output logic             unbonded_pad_pullup_44_o,
    output logic             unbonded_pad_pullup_32_o,
    output logic             readout_protect_n_o,
    output logic             alt_function_remap_1_o,
    output logic             alt_function_remap_0_o,
    output logic [1:0]       clock_source_type_o,
    output logic [1:0]       oscillator_range_sel_o,
    output logic             reset_phase_length_sel_o,
    output logic [12:0]      reset_phase_cycles_o
);

    // ==========================================================
    // Access gating
    logic op_ok;
    logic op_wr;
    logic op_erase;
    logic op_read;
    logic wipe_done;

    assign op_ok    = prog_mode_i & prog_strobe_i & ~prog_busy_o;
    assign op_wr    = op_ok & (prog_cmd_i == obc_pkg::OBC_CMD_WRITE);
    assign op_erase = op_ok & (prog_cmd_i == obc_pkg::OBC_CMD_ERASE);
    assign op_read  = op_ok & (prog_cmd_i == obc_pkg::OBC_CMD_READ);

    // ==========================================================
    // Storage cells
    logic [7:0] opt0;
    logic [7:0] opt1;
    logic       prot_now;
    logic       cell_erase;
    logic       erase_pend_r;

    assign prot_now   = ~opt0[obc_pkg::B0_RDP_N];
    assign cell_erase = (op_erase & ~prot_now) | wipe_done;

    obc_opt_cell #(
        .MASK_ROM  (MASK_ROM),
        .ROM_VALUE (ROM_OPT0),
        .BLANK     (obc_pkg::OPT0_DEFAULT)
    ) u_opt0 (
        .clk_i     (clk_i),
        .srst_i    (srst_i),
        .wr_i      (op_wr & ~prog_sel_i),
        .erase_i   (cell_erase),
        .wdata_i   (prog_wdata_i),
        .value_o   (opt0)
    );

    obc_opt_cell #(
        .MASK_ROM  (MASK_ROM),
        .ROM_VALUE (ROM_OPT1),
        .BLANK     (obc_pkg::OPT1_DEFAULT)
    ) u_opt1 (
        .clk_i     (clk_i),
        .srst_i    (srst_i),
        .wr_i      (op_wr & prog_sel_i),
        .erase_i   (cell_erase),
        .wdata_i   (prog_wdata_i),
        .value_o   (opt1)
    );

    // ==========================================================
    // Protected erase: wipe user memory, then the option bytes
    typedef enum logic [0:0] {
        OBC_IDLE = 1'b0,
        OBC_WIPE = 1'b1
    } obc_state_type;

    obc_state_type state_r;
    obc_state_type state_nxt;
    logic [15:0]   wipe_addr_r;
    logic [15:0]   wipe_addr_nxt;
    logic          wipe_last;

    assign wipe_last = (wipe_addr_r == 16'(WIPE_WORDS - 1));
    assign wipe_done = (state_r == OBC_WIPE) & wipe_last;

    always_comb
    begin
        state_nxt     = state_r;
        wipe_addr_nxt = wipe_addr_r;
        case (state_r)
            OBC_IDLE:
            begin
                if (op_erase && prot_now)
                begin
                    state_nxt     = OBC_WIPE;
                    wipe_addr_nxt = 16'h0000;
                end
            end
            OBC_WIPE:
            begin
                if (wipe_last)
                    state_nxt = OBC_IDLE;
                else
                    wipe_addr_nxt = wipe_addr_r + 16'h0001;
            end
            default:
                state_nxt = OBC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_r     <= OBC_IDLE;
            wipe_addr_r <= 16'h0000;
        end
        else
        begin
            state_r     <= state_nxt;
            wipe_addr_r <= wipe_addr_nxt;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            erase_pend_r <= 1'b0;
        else
            erase_pend_r <= wipe_done;
    end

    assign prog_busy_o   = (state_r == OBC_WIPE) | erase_pend_r;
    assign wipe_active_o = (state_r == OBC_WIPE);
    assign wipe_addr_o   = wipe_addr_r;

    // ==========================================================
    // Programming read-back; outside programming mode reads zero
    logic [7:0] rdata_r;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            rdata_r <= 8'h00;
        else if (op_read)
            rdata_r <= prog_sel_i ? opt1 : opt0;
        else
            rdata_r <= 8'h00;
    end

    assign prog_rdata_o = rdata_r;

    // ==========================================================
    // Configuration latched while reset is held, frozen afterwards
    logic [7:0] cfg0_r;
    logic [7:0] cfg1_r;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            cfg0_r <= opt0;
            cfg1_r <= opt1;
        end
    end

    // ==========================================================
    // Decoding
    logic [1:0] pkg_bits;
    logic       pkg_64;

    assign halt_entry_watchdog_reset_sel_o = cfg0_r[obc_pkg::B0_HALT_RST];
    assign watchdog_type_sel_o             = cfg0_r[obc_pkg::B0_WDG_SW];
    assign low_voltage_detector_off_o      = cfg0_r[obc_pkg::B0_LVD_OFF];
    assign clock_doubler_en_o              = ~cfg0_r[obc_pkg::B0_DBL_OFF];
    assign readout_protect_n_o             = cfg0_r[obc_pkg::B0_RDP_N];

    assign pkg_bits = {cfg0_r[obc_pkg::B0_PKG_HI], cfg0_r[obc_pkg::B0_PKG_LO]};
    assign pkg_64   = pkg_bits[1];
    assign package_sel_o = pkg_64       ? obc_pkg::OBC_PKG_64
                         : pkg_bits[0]  ? obc_pkg::OBC_PKG_44
                         : obc_pkg::OBC_PKG_32;

    // Pads missing from smaller packages held as pulled-up inputs
    assign unbonded_pad_pullup_44_o = ~pkg_64;
    assign unbonded_pad_pullup_32_o = ~pkg_64 & ~pkg_bits[0];

    assign alt_function_remap_1_o = cfg1_r[obc_pkg::B1_REMAP1];
    assign alt_function_remap_0_o = cfg1_r[obc_pkg::B1_REMAP0];
    assign clock_source_type_o    =
        {cfg1_r[obc_pkg::B1_CLK_HI], cfg1_r[obc_pkg::B1_CLK_LO]};
    assign oscillator_range_sel_o =
        {cfg1_r[obc_pkg::B1_RNG_HI], cfg1_r[obc_pkg::B1_RNG_LO]};
    assign reset_phase_length_sel_o = cfg1_r[obc_pkg::B1_RESET_PHASE_LENGTH_SEL];
    assign reset_phase_cycles_o = cfg1_r[obc_pkg::B1_RESET_PHASE_LENGTH_SEL]
                                ? obc_pkg::PHASE_SHORT : obc_pkg::PHASE_LONG;

endmodule

// *** bench/obc_decoder_properties.sv ***
/* Port checker for the option byte decoder.
   Assumes it is bound to obc_decoder and sees its ports only. */
module obc_decoder_properties #(
    parameter int WIPE_WORDS = 8
) (
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        prog_mode_i,
    input wire logic        prog_strobe_i,
    input wire logic [1:0]  prog_cmd_i,
    input wire logic [7:0]  prog_rdata_o,
    input wire logic        prog_busy_o,
    input wire logic        wipe_active_o,
    input wire logic [15:0] wipe_addr_o,
    input wire logic [1:0]  package_sel_o,
    input wire logic        unbonded_pad_pullup_44_o,
    input wire logic        unbonded_pad_pullup_32_o,
    input wire logic        readout_protect_n_o,
    input wire logic [1:0]  clock_source_type_o,
    input wire logic        reset_phase_length_sel_o,
    input wire logic [12:0] reset_phase_cycles_o
);
    // ==========================================
    // Wipe length counter
    logic [15:0] wcnt_r;
    always_ff @(posedge clk_i)
        if (srst_i || !wipe_active_o)
            wcnt_r <= 16'h0;
        else
            wcnt_r <= wcnt_r + 16'h1;

    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    property p_rd_idle;
        !$past(prog_mode_i && prog_strobe_i && prog_cmd_i == 2'h0 && !prog_busy_o)
            |-> prog_rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_pu44;
        unbonded_pad_pullup_44_o == (package_sel_o != 2'h2);
    endproperty
    a_pu44: assert property (p_pu44) else $error("44 pad pull-up wrong");
    property p_pu32;
        unbonded_pad_pullup_32_o == (package_sel_o == 2'h0);
    endproperty
    a_pu32: assert property (p_pu32) else $error("32 pad pull-up wrong");
    property p_pkg;
        package_sel_o != 2'h3;
    endproperty
    a_pkg: assert property (p_pkg) else $error("bad package code");
    property p_cyc;
        reset_phase_cycles_o == (reset_phase_length_sel_o ? 13'h0100 : 13'h1000);
    endproperty
    a_cyc: assert property (p_cyc) else $error("phase length wrong");
    property p_hold;
        !$past(srst_i) |-> $stable({package_sel_o, clock_source_type_o,
            readout_protect_n_o, reset_phase_length_sel_o});
    endproperty
    a_hold: assert property (p_hold) else $error("config moved while running");
    property p_wstart;
        $rose(wipe_active_o) |-> prog_busy_o && wipe_addr_o == 16'h0;
    endproperty
    a_wstart: assert property (p_wstart) else $error("wipe start wrong");
    property p_wstep;
        wipe_active_o && $past(wipe_active_o) |-> wipe_addr_o == $past(wipe_addr_o) + 16'h1;
    endproperty
    a_wstep: assert property (p_wstep) else $error("wipe address skipped");
    property p_wlen;
        $fell(wipe_active_o) |-> wcnt_r == 16'(WIPE_WORDS) && prog_busy_o ##1 !prog_busy_o;
    endproperty
    a_wlen: assert property (p_wlen) else $error("wipe length wrong");
    property p_refuse;
        !prog_mode_i && prog_strobe_i |=> !$rose(wipe_active_o);
    endproperty
    a_refuse: assert property (p_refuse) else $error("command taken outside mode");
    c_read: cover property (prog_mode_i && prog_strobe_i && prog_cmd_i == 2'h0);
    c_wipe: cover property ($rose(wipe_active_o));
    c_pkg44: cover property (package_sel_o == 2'h1);
endmodule

bind obc_decoder obc_decoder_properties #(.WIPE_WORDS(WIPE_WORDS)) u_props (.*);

// *** bench/obc_tool.sv ***
/* Programming tool model: issues one command per call.
   Assumes the decoder answers reads one cycle after the strobe. */
module obc_tool (
    input  wire logic       clk_i,
    input  wire logic [7:0] prog_rdata_i,
    output logic            prog_mode_o,
    output logic            prog_sel_o,
    output logic [1:0]      prog_cmd_o,
    output logic            prog_strobe_o,
    output logic [7:0]      prog_wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        prog_mode_o   = 1'b0;
        prog_sel_o    = 1'b0;
        prog_cmd_o    = 2'h3;
        prog_strobe_o = 1'b0;
        prog_wdata_o  = 8'h5a;
    end
    // ==========================================
    // One command, mode left as given
    task automatic op(input logic m, s, input logic [1:0] c, input logic [7:0] d,
                      output logic [7:0] rd);
        @(posedge clk_i);
        prog_mode_o   <= m;
        prog_sel_o    <= s;
        prog_cmd_o    <= c;
        prog_wdata_o  <= s ? d : (d | 8'h20);
        prog_strobe_o <= 1'b1;
        @(posedge clk_i);
        prog_strobe_o <= 1'b0;
        prog_wdata_o  <= ~prog_wdata_o;
        @(posedge clk_i);
        rd = prog_rdata_i;
    endtask
endmodule

// *** bench/tb_option_byte_config_decoder.sv ***
/* Self-checking bench for the option byte decoder.
   Assumes obc_tool drives the programming port. */
module tb_option_byte_config_decoder;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WW = 8;
    logic        clk_i;
    logic        srst_i;
    wire         mode, sel, strobe, busy, wact;
    wire  [1:0]  cmd;
    wire  [7:0]  wdata, rdata;
    wire  [15:0] waddr;
    wire  [28:0] cfg;
    wire  [28:0] cfg_rom;
    int          n_fail, n_compared, cyc;
    // Reserved bits kept; doubler only with 2-4 MHz; ext clock has range
    // Resonator paired with 4096 cycles
    // Configs cover 64, 44 and 32 pins, so unbonded pad pull-ups are checked
    logic [7:0] c0 [3] = '{8'h3d, 8'he3, 8'hf9};
    logic [7:0] c1 [3] = '{8'h02, 8'hb7, 8'h5a};

    obc_tool u_tool (.clk_i(clk_i), .prog_rdata_i(rdata), .prog_mode_o(mode),
        .prog_sel_o(sel), .prog_cmd_o(cmd), .prog_strobe_o(strobe), .prog_wdata_o(wdata));
    obc_decoder #(.WIPE_WORDS(WW)) u_dut (.clk_i(clk_i), .srst_i(srst_i),
        .prog_mode_i(mode), .prog_sel_i(sel), .prog_cmd_i(cmd), .prog_strobe_i(strobe),
        .prog_wdata_i(wdata), .prog_rdata_o(rdata), .prog_busy_o(busy),
        .wipe_active_o(wact), .wipe_addr_o(waddr),
        .halt_entry_watchdog_reset_sel_o(cfg[28]), .watchdog_type_sel_o(cfg[27]),
        .low_voltage_detector_off_o(cfg[26]), .clock_doubler_en_o(cfg[25]),
        .package_sel_o(cfg[24:23]), .unbonded_pad_pullup_44_o(cfg[22]),
        .unbonded_pad_pullup_32_o(cfg[21]), .readout_protect_n_o(cfg[20]),
        .alt_function_remap_1_o(cfg[19]), .alt_function_remap_0_o(cfg[18]),
        .clock_source_type_o(cfg[17:16]), .oscillator_range_sel_o(cfg[15:14]),
        .reset_phase_length_sel_o(cfg[13]), .reset_phase_cycles_o(cfg[12:0]));
    // Mask part on the same port: commands must leave its options alone
    obc_decoder #(.WIPE_WORDS(WW), .MASK_ROM(1'b1),
        .ROM_OPT0(8'h67), .ROM_OPT1(8'hb6)) u_rom (.clk_i(clk_i), .srst_i(srst_i),
        .prog_mode_i(mode), .prog_sel_i(sel), .prog_cmd_i(cmd), .prog_strobe_i(strobe),
        .prog_wdata_i(wdata), .prog_rdata_o(), .prog_busy_o(),
        .wipe_active_o(), .wipe_addr_o(),
        .halt_entry_watchdog_reset_sel_o(cfg_rom[28]), .watchdog_type_sel_o(cfg_rom[27]),
        .low_voltage_detector_off_o(cfg_rom[26]), .clock_doubler_en_o(cfg_rom[25]),
        .package_sel_o(cfg_rom[24:23]), .unbonded_pad_pullup_44_o(cfg_rom[22]),
        .unbonded_pad_pullup_32_o(cfg_rom[21]), .readout_protect_n_o(cfg_rom[20]),
        .alt_function_remap_1_o(cfg_rom[19]), .alt_function_remap_0_o(cfg_rom[18]),
        .clock_source_type_o(cfg_rom[17:16]), .oscillator_range_sel_o(cfg_rom[15:14]),
        .reset_phase_length_sel_o(cfg_rom[13]), .reset_phase_cycles_o(cfg_rom[12:0]));

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // ==========================================
    // Checking helpers
    function automatic logic [28:0] exp_cfg(input logic [7:0] b0, b1);
        logic [1:0] pk;
        pk = b0[2] ? 2'h2 : {1'b0, b0[1]};
        return {b0[7], b0[6], b0[4], ~b0[3], pk, pk != 2'h2, pk == 2'h0, b0[0],
                b1[7:2], b1[0], b1[0] ? 13'h0100 : 13'h1000};
    endfunction
    task automatic chk(input logic [28:0] got, exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rst();
        @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
    endtask
    task automatic wr(input logic s, input logic [1:0] c, input logic [7:0] d);
        logic [7:0] x;
        u_tool.op(1'b1, s, c, d, x);
    endtask
    task automatic rdchk(input logic m, s, input logic [7:0] e);
        logic [7:0] x;
        u_tool.op(m, s, 2'h0, 8'h00, x);
        chk(29'(x), 29'(e));
    endtask
    // ==========================================
    // Scenarios
    task automatic t_defaults();
        chk(cfg, exp_cfg(8'hff, 8'hef));
        rdchk(1'b1, 1'b0, 8'hff);
        rdchk(1'b1, 1'b1, 8'hef);
    endtask
    task automatic t_configs();
        logic [28:0] prev;
        for (int i = 0; i < 3; i++)
        begin
            prev = cfg;
            wr(1'b0, 2'h2, 8'h00);
            wr(1'b0, 2'h1, c0[i]);
            wr(1'b1, 2'h1, c1[i]);
            chk(cfg, prev);
            rst();
            chk(cfg, exp_cfg(c0[i], c1[i]));
            rdchk(1'b1, 1'b1, c1[i]);
        end
    endtask
    task automatic t_refuse();
        logic [7:0] x;
        u_tool.op(1'b0, 1'b0, 2'h1, 8'h00, x);
        rdchk(1'b0, 1'b0, 8'h00);
        rdchk(1'b1, 1'b0, 8'hf9);
        chk(cfg_rom, exp_cfg(8'h67, 8'hb6));
    endtask
    task automatic t_wipe();
        int n;
        wr(1'b0, 2'h1, 8'hfe);
        rst();
        chk(cfg, exp_cfg(8'hf8, 8'h5a));
        wr(1'b0, 2'h2, 8'h00);
        chk(29'(busy), 29'h1);
        wr(1'b1, 2'h1, 8'h00);
        rdchk(1'b1, 1'b1, 8'h00);
        n = 0;
        while (busy !== 1'b0 && n < 40)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(29'(n < 40), 29'h1);
        rdchk(1'b1, 1'b0, 8'hff);
        rdchk(1'b1, 1'b1, 8'hff);
    endtask
    // ==========================================
    // Run control
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_fail++;
            $display("MISMATCH t=%0t timeout", $time);
            finish_test();
        end
    end
    initial
    begin
        srst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        t_defaults();
        t_configs();
        t_refuse();
        t_wipe();
        finish_test();
    end
endmodule
